/* File: verilog/brk_pkg.sv */
// constants and carrier types for the address breakpoint unit
// How it works
// - enabled unit requests a break when the fetch address equals the match address
// - break request forces the interrupt opcode and the right vector pair
// - writing one to break_active raises a break without any match
// - break starts at instruction end, or at once on a match while in wait or stop mode
// - timer counters halt and input captures are blocked while break is active
// - watchdog is off in break while test voltage sits on reset
// - break in stop mode wakes the device and sets stop_wait_break_flag
// - break_enable is bit 7, read/write, cleared by reset
// - break_active sets on match, cleared by writing zero or reset
// - match address high and low bytes are read/write, reset to zero
// - break_wait_flag sets on wake from wait, cleared by zero write or reset
// - other status flags clear during break only while clear enable is one
// - return from interrupt in the break routine ends the break state
// - comparison keeps working while the device waits
package brk_pkg;
   // ****************************************
   // register map (byte addresses)
   // ****************************************
   localparam logic [11:0] OFS_CTRL_STATUS = 12'h000;
   localparam logic [11:0] OFS_ADDR_HI = 12'h004;
   localparam logic [11:0] OFS_ADDR_LO = 12'h008;
   localparam logic [11:0] OFS_WAKE_STATUS = 12'h00c;
   localparam logic [11:0] OFS_FLAG_CLEAR = 12'h010;
   localparam logic [11:0] OFS_IRQ_STATUS = 12'h014;
   localparam logic [11:0] OFS_IRQ_MASK = 12'h018;
   // ****************************************
   // field positions
   // ****************************************
   localparam int BIT_ENABLE = 7;
   localparam int BIT_ACTIVE = 6;
   localparam int BIT_WAIT_FLAG = 1;
   localparam int BIT_STOP_FLAG = 0;
   localparam int BIT_CLEAR_EN = 7;
   localparam int IRQ_BIT_BREAK = 0;
   localparam int IRQ_BIT_WAKE = 1;
   // ****************************************
   // reset values and vectors
   // ****************************************
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [15:0] VEC_NORMAL = 16'hfffc;
   localparam logic [15:0] VEC_MONITOR = 16'hfefc;
   localparam logic [7:0] SWI_OPCODE = 8'h83;
   // cpu status bundle
   typedef struct packed {
      logic [15:0] pc;
      logic fetch;
      logic last_cycle;
      logic rti_exec;
      logic monitor_mode;
      logic wait_mode;
      logic stop_mode;
   } cpu_status_t;
   // forced-fetch bundle toward the cpu
   typedef struct packed {
      logic force_swi;
      logic [7:0] opcode;
      logic [15:0] vector;
   } brk_force_t;
   typedef enum logic [1:0] {ST_IDLE, ST_PENDING, ST_BREAK} brk_state_t;
endpackage

/* File: verilog/address_breakpoint_unit.sv */
// address breakpoint unit with apb register slave
`timescale 1ns/1ps
`default_nettype none
module address_breakpoint_unit (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // cpu side
   input wire brk_pkg::cpu_status_t cpu,
   output brk_pkg::brk_force_t force_o,
   // system integration side
   output logic brk_request,
   output logic wake_o,
   output logic timer_halt,
   output logic capture_block,
   output logic flag_clear_allow,
   output logic watchdog_disable,
   input wire logic test_voltage_pin,
   // interrupt
   output logic irq
);
   import brk_pkg::*;
   logic enable_ff, active_ff, wait_flag_ff, stop_flag_ff, clear_en_ff;
   logic [7:0] addr_hi_ff, addr_lo_ff;
   logic [1:0] irq_stat_ff, irq_mask_ff;
   brk_state_t state_ff;
   logic tv_s1_ff, tv_s2_ff;
   logic wr, rd, match, sw_break, trig, enter, in_break;
   logic [31:0] nxt_rdata;
   // ****************************************
   // bus decode
   // ****************************************
   // byte registers on bus clock
   assign wr = psel & penable & pwrite;
   assign rd = psel & penable & ~pwrite;
   assign pready = 1'b1;
   always_comb begin
      nxt_rdata = 32'h0;
      pslverr = 1'b0;
      unique case (paddr)
         OFS_CTRL_STATUS: nxt_rdata[7:0] = {enable_ff, active_ff, 6'h00};
         OFS_ADDR_HI: nxt_rdata[7:0] = addr_hi_ff;
         OFS_ADDR_LO: nxt_rdata[7:0] = addr_lo_ff;
         OFS_WAKE_STATUS: nxt_rdata[7:0] = {6'h00, wait_flag_ff, stop_flag_ff};
         OFS_FLAG_CLEAR: nxt_rdata[7:0] = {clear_en_ff, 7'h00};
         OFS_IRQ_STATUS: nxt_rdata[1:0] = irq_stat_ff;
         OFS_IRQ_MASK: nxt_rdata[1:0] = irq_mask_ff;
         default: pslverr = psel & penable;
      endcase
   end
   // read data is combinational on the single access cycle
   assign prdata = rd ? nxt_rdata : 32'h0;
   // ****************************************
   // match and trigger
   // ****************************************
   // address compare, no wait gating
   assign match = enable_ff & cpu.fetch & (cpu.pc == {addr_hi_ff, addr_lo_ff});
   assign sw_break = wr & (paddr == OFS_CTRL_STATUS) & pwdata[BIT_ACTIVE];
   assign trig = match | sw_break;
   assign enter = (state_ff == ST_PENDING & cpu.last_cycle) |
                  (state_ff == ST_IDLE & trig & cpu.last_cycle) |
                  (state_ff == ST_IDLE & trig & (cpu.wait_mode | cpu.stop_mode));
   assign in_break = (state_ff == ST_BREAK);
   // break sequencer
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_ff <= ST_IDLE;
      end else begin
         unique case (state_ff)
            ST_IDLE: begin
               if (enter) state_ff <= ST_BREAK;
               else if (trig) state_ff <= ST_PENDING;
            end
            ST_PENDING: begin
               if (enter) state_ff <= ST_BREAK;
            end
            ST_BREAK: begin
               if (cpu.rti_exec) state_ff <= ST_IDLE;
            end
            // the spare state code falls back to idle
            default: begin
               state_ff <= ST_IDLE;
            end
         endcase
      end
   end
   // ****************************************
   // control and status registers
   // ****************************************
   // plain read/write fields
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         enable_ff <= 1'b0;
         addr_hi_ff <= RST_BYTE;
         addr_lo_ff <= RST_BYTE;
         clear_en_ff <= 1'b0;
      end else if (wr) begin
         if (paddr == OFS_CTRL_STATUS) enable_ff <= pwdata[BIT_ENABLE];
         if (paddr == OFS_ADDR_HI) addr_hi_ff <= pwdata[7:0];
         if (paddr == OFS_ADDR_LO) addr_lo_ff <= pwdata[7:0];
         if (paddr == OFS_FLAG_CLEAR) clear_en_ff <= pwdata[BIT_CLEAR_EN];
      end
   end
   // active flag, set wins over clear
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         active_ff <= 1'b0;
      end else if (trig) begin
         active_ff <= 1'b1;
      end else if (wr & (paddr == OFS_CTRL_STATUS) & ~pwdata[BIT_ACTIVE]) begin
         active_ff <= 1'b0;
      end
   end
   // wake flags, set wins over clear
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wait_flag_ff <= 1'b0;
         stop_flag_ff <= 1'b0;
      end else begin
         if (enter & cpu.wait_mode) wait_flag_ff <= 1'b1;
         else if (wr & (paddr == OFS_WAKE_STATUS) & ~pwdata[BIT_WAIT_FLAG])
            wait_flag_ff <= 1'b0;
         if (enter & cpu.stop_mode) stop_flag_ff <= 1'b1;
         else if (wr & (paddr == OFS_WAKE_STATUS) & ~pwdata[BIT_STOP_FLAG])
            stop_flag_ff <= 1'b0;
      end
   end
   // ****************************************
   // interrupt status and mask
   // ****************************************
   // sticky events, write one to clear, set wins
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         irq_stat_ff <= 2'b00;
         irq_mask_ff <= 2'b00;
      end else begin
         irq_stat_ff[IRQ_BIT_BREAK] <= enter |
            (irq_stat_ff[IRQ_BIT_BREAK] & ~(wr & (paddr == OFS_IRQ_STATUS) & pwdata[0]));
         irq_stat_ff[IRQ_BIT_WAKE] <= (enter & (cpu.wait_mode | cpu.stop_mode)) |
            (irq_stat_ff[IRQ_BIT_WAKE] & ~(wr & (paddr == OFS_IRQ_STATUS) & pwdata[1]));
         if (wr & (paddr == OFS_IRQ_MASK)) irq_mask_ff <= pwdata[1:0];
      end
   end
   assign irq = |(irq_stat_ff & irq_mask_ff);
   // ****************************************
   // test voltage synchroniser
   // ****************************************
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tv_s1_ff <= 1'b0;
         tv_s2_ff <= 1'b0;
      end else begin
         tv_s1_ff <= test_voltage_pin;
         tv_s2_ff <= tv_s1_ff;
      end
   end
   // ****************************************
   // outputs toward cpu and system
   // ****************************************
   // forced opcode and vector, registered
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         force_o <= '0;
         brk_request <= 1'b0;
         wake_o <= 1'b0;
      end else begin
         force_o.force_swi <= enter;
         force_o.opcode <= enter ? SWI_OPCODE : RST_BYTE;
         force_o.vector <= cpu.monitor_mode ? VEC_MONITOR : VEC_NORMAL;
         brk_request <= enter;
         wake_o <= enter & cpu.stop_mode;
      end
   end
   assign timer_halt = in_break;
   assign capture_block = in_break;
   assign watchdog_disable = in_break & tv_s2_ff;
   assign flag_clear_allow = ~in_break | clear_en_ff;
endmodule
`default_nettype wire

/* File: sim/brk_checker.sv */
// port assertions for the address breakpoint unit
`timescale 1ns/1ps
`default_nettype none
module brk_checker import brk_pkg::*; (
   // watched ports
   input wire logic clk, resetn, psel, penable, pwrite, pready, pslverr,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire cpu_status_t cpu,
   input wire brk_force_t force_o,
   input wire logic brk_request, wake_o, timer_halt, capture_block,
   input wire logic flag_clear_allow, watchdog_disable
);
   logic acc;
   // access phase of a transfer
   assign acc = psel && penable;
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   a_no_wait: assert property (acc |-> pready) else $error("wait state");
   a_bad_addr: assert property (acc && paddr > OFS_IRQ_MASK |-> pslverr) else $error("no err");
   a_force_pair: assert property (brk_request |-> force_o.force_swi
      && force_o.opcode == SWI_OPCODE) else $error("no forced opcode");
   a_vector_pick: assert property (brk_request && $stable(cpu.monitor_mode) |->
      force_o.vector == (cpu.monitor_mode ? VEC_MONITOR : VEC_NORMAL)) else $error("vector");
   a_soft_break: assert property (acc && pwrite && paddr == OFS_CTRL_STATUS
      && pwdata[BIT_ACTIVE] && cpu.last_cycle && !timer_halt |=> brk_request) else $error("soft");
   a_halt_entry: assert property ($rose(timer_halt) |-> brk_request
      && capture_block) else $error("halt");
   a_wdog_gate: assert property (watchdog_disable |-> timer_halt) else $error("watchdog");
   a_stop_wake: assert property (wake_o |-> brk_request && $past(cpu.stop_mode)) else $error("wake");
   a_clear_gate: assert property (!timer_halt |-> flag_clear_allow) else $error("clear");
   a_break_hold: assert property (timer_halt && !cpu.rti_exec |=> timer_halt) else $error("hold");
   a_rti_exit: assert property (timer_halt && cpu.rti_exec |=> !timer_halt) else $error("rti");
endmodule
bind address_breakpoint_unit brk_checker i_brk_checker (.clk, .resetn, .psel, .penable,
   .pwrite, .pready, .pslverr, .paddr, .pwdata, .cpu, .force_o, .brk_request, .wake_o,
   .timer_halt, .capture_block, .flag_clear_allow, .watchdog_disable);
`default_nettype wire

/* File: sim/cpu_model.sv */
// behavioural cpu core feeding fetch status to the breakpoint unit
`timescale 1ns/1ps
`default_nettype none
module cpu_model import brk_pkg::*; (
   // controls from the bench, forced fetch in, status out
   input wire logic clk, resetn, rti_go, wt, stp, mon,
   input wire logic [1:0] len,
   input wire brk_force_t force_o,
   output cpu_status_t cpu
);
   logic [15:0] pc_ff;
   logic [1:0] cyc_ff;
   logic lst;
   // instruction stream; a forced fetch reloads the counter from the vector
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pc_ff <= 16'h0100;
         cyc_ff <= 2'h0;
      end else begin
         cyc_ff <= (force_o.force_swi || lst) ? 2'h0 : cyc_ff + {1'b0, !(wt | stp)};
         pc_ff <= force_o.force_swi ? force_o.vector : pc_ff + {15'h0, lst};
      end
   end
   // low-power modes freeze the stream, so no instruction ends there
   assign lst = !(wt | stp) && cyc_ff == len - 2'h1;
   assign cpu = {pc_ff, 1'b1, lst, rti_go && lst, mon, wt, stp};
endmodule
`default_nettype wire

/* File: sim/address_breakpoint_unit_tb.sv */
// self-checking bench for the address breakpoint unit
`timescale 1ns/1ps
`default_nettype none
module address_breakpoint_unit_tb;
   import brk_pkg::*;
   logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, tvp = 0, rti_go = 0;
   logic wt = 0, stp = 0, mon = 0, pready, pslverr, err, wk, brk_request, wake_o, irq;
   logic timer_halt, capture_block, flag_clear_allow, watchdog_disable;
   logic [1:0] len = 2'h2;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic [15:0] tgt;
   cpu_status_t cpu;
   brk_force_t force_o;
   int n_mismatch = 0, checks = 0, mdl[int];
   always #5 clk = ~clk;
   address_breakpoint_unit i_address_breakpoint_unit (.clk, .resetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .cpu, .force_o, .brk_request, .wake_o,
      .timer_halt, .capture_block, .flag_clear_allow, .watchdog_disable,
      .test_voltage_pin(tvp), .irq);
   cpu_model i_cpu_model (.clk, .resetn, .rti_go, .wt, .stp, .mon, .len, .force_o, .cpu);
   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // one transfer; request stands until ready is sampled high
   task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
      int n;
      @(posedge clk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge clk);
      penable <= 1;
      for (n = 0; n < 9; n++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      if (n == 9) n_mismatch++;
      if (n == 9) end_of_test();
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
      if (w && mdl.exists(a)) mdl[a] = d[7:0];
      else if (mdl.exists(a)) chk("readback", mdl[a], rd);
   endtask
   task automatic wait_brk();
      int n;
      for (n = 0; n < 150 && brk_request !== 1'b1; n++) @(posedge clk);
      wk = wake_o;
      chk("brk_request", 1, n < 150);
   endtask
   // clear the active bit, then let the routine return
   task automatic leave();
      apb(1, OFS_CTRL_STATUS, 0);
      rti_go <= 1;
      for (int n = 0; n < 9 && timer_halt !== 1'b0; n++) @(posedge clk);
      rti_go <= 0;
      chk("timer_halt", 0, timer_halt);
   endtask
   task automatic set_match(logic [15:0] t);
      apb(1, OFS_ADDR_HI, {24'h0, t[15:8]});
      apb(1, OFS_ADDR_LO, {24'h0, t[7:0]});
      apb(1, OFS_CTRL_STATUS, 32'h80);
   endtask
   initial begin
      void'($urandom(2006));
      len <= 2'h1 + 2'($urandom % 3);
      for (int a = 4; a <= 24; a += 4) mdl[a] = 0;
      mdl.delete(OFS_WAKE_STATUS);
      mdl.delete(OFS_IRQ_STATUS);
      repeat (5) @(posedge clk);
      resetn <= 1;
      // walk downward so the last read is the control byte
      for (int a = 24; a >= 0; a -= 4) apb(0, 12'(a), 0);
      chk("ctrl reset", 0, rd);
      apb(0, OFS_WAKE_STATUS, 0);
      chk("wake reset", 0, rd);
      $display("test reset done");
      tgt = cpu.pc + 16'h20 + 16'($urandom % 16);
      set_match(tgt);
      apb(0, OFS_ADDR_LO, 0);
      wait_brk();
      chk("vector", VEC_NORMAL, force_o.vector);
      apb(0, OFS_CTRL_STATUS, 0);
      chk("ctrl", 32'hc0, rd);
      chk("halt", 3, {capture_block, timer_halt});
      chk("clear allow", 0, flag_clear_allow);
      apb(1, OFS_FLAG_CLEAR, 32'h80);
      tvp <= 1;
      repeat (4) @(posedge clk);
      chk("clear allow", 1, flag_clear_allow);
      chk("watchdog off", 1, watchdog_disable);
      tvp <= 0;
      apb(0, OFS_IRQ_STATUS, 0);
      chk("irq status", 1, rd);
      chk("irq masked", 0, irq);
      apb(1, OFS_IRQ_MASK, 1);
      // the write lands at the sampling edge; look one edge later
      @(posedge clk);
      chk("irq", 1, irq);
      apb(1, OFS_IRQ_STATUS, 1);
      @(posedge clk);
      chk("irq cleared", 0, irq);
      leave();
      $display("test address break done");
      mon <= 1;
      apb(1, OFS_CTRL_STATUS, 32'h40);
      wait_brk();
      chk("monitor vector", VEC_MONITOR, force_o.vector);
      leave();
      mon <= 0;
      wt <= 1;
      @(posedge clk);
      set_match(cpu.pc);
      wait_brk();
      apb(0, OFS_WAKE_STATUS, 0);
      chk("wait flag", 2, rd);
      apb(1, OFS_WAKE_STATUS, 0);
      apb(0, OFS_WAKE_STATUS, 0);
      chk("wait flag", 0, rd);
      // routine returns from wait: the bench drops wait so the model can end an instruction and return
      wt <= 0;
      leave();
      stp <= 1;
      apb(1, OFS_CTRL_STATUS, 32'h40);
      wait_brk();
      chk("wake", 1, wk);
      apb(0, OFS_WAKE_STATUS, 0);
      chk("stop flag", 1, rd);
      stp <= 0;
      leave();
      $display("test low power done");
      apb(1, 12'h01c, 32'hff);
      chk("slave error", 1, err);
      apb(0, 12'h01c, 0);
      chk("unmapped", 0, rd);
      end_of_test();
   end
   initial begin
      #400000;
      n_mismatch++;
      end_of_test();
   end
endmodule
`default_nettype wire
